// >>> dv/astd_exec_asserts.sv
`include "astd_defs.vh"
`timescale 1ns/100ps
module astd_exec_asserts (
    input wire clock,
    input wire nrst,
    input wire ce,
    input wire exec,
    input wire [9:0] opcode,
    input wire [3:0] acc,
    input wire [3:0] breg,
    input wire [3:0] xin,
    input wire [2:0] data_ptr,
    input wire [7:0] wide_reg,
    input wire [3:0] yreg,
    input wire [3:0] xreg,
    input wire x_wr,
    input wire y_wr,
    input wire [7:0] prescaler,
    input wire [7:0] prescaler_reload,
    input wire prescaler_load,
    input wire [7:0] serial_shift,
    input wire timer_bit,
    input wire watchdog_flag_first,
    input wire watchdog_run,
    input wire skip_next,
    input wire carry_keep
);
    // An opcode only counts when the clock enable lets it through
    wire go = ce & exec;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    ptr_load_a: assert property (go && opcode == `ASTD_OP_DPTR |=> data_ptr == $past(acc[2:0]))
        else $error("pointer load wrong");
    wide_load_a: assert property (go && opcode == `ASTD_OP_EREG |=> wide_reg == {$past(breg), $past(acc)})
        else $error("wide register load wrong");
    store_xor_a: assert property (go && opcode[9:4] == `ASTD_OP_STM_HI |=>
        x_wr && xreg == ($past(xin) ^ $past(opcode[3:0]))) else $error("store x update wrong");
    timer_bit_a: assert property (go && opcode == `ASTD_OP_TBIT |=> timer_bit == $past(acc[0]))
        else $error("timer bit wrong");
    presc_pair_a: assert property (go && opcode == `ASTD_OP_PRE |=> prescaler_load &&
        prescaler == {$past(breg), $past(acc)} && prescaler_reload == prescaler) else $error("prescaler wrong");
    shift_pair_a: assert property (go && opcode == `ASTD_OP_SHF |=> serial_shift == {$past(breg), $past(acc)})
        else $error("shift register wrong");
    row_load_a: assert property (go && opcode == `ASTD_OP_YREG |=> y_wr && yreg == $past(acc) && !skip_next)
        else $error("y load wrong");
    wd_skip_a: assert property (go && opcode == `ASTD_OP_WDS |=> skip_next == $past(watchdog_flag_first))
        else $error("watchdog skip wrong");
    wd_stop_a: assert property (go && opcode == `ASTD_OP_WDD ##1 go && opcode == `ASTD_OP_WDS |=> !watchdog_run)
        else $error("watchdog not stopped");
    group_carry_a: assert property (go && opcode == `ASTD_OP_CLK |=> carry_keep && !skip_next)
        else $error("group flag wrong");
endmodule // astd_exec_asserts

bind astd_exec astd_exec_asserts chk_i (.clock, .nrst, .ce, .exec, .opcode, .acc, .breg, .xin, .data_ptr,
    .wide_reg, .yreg, .xreg, .x_wr, .y_wr, .prescaler, .prescaler_reload, .prescaler_load, .serial_shift,
    .timer_bit, .watchdog_flag_first, .watchdog_run, .skip_next, .carry_keep);

// >>> dv/test_astd_exec.sv
`include "astd_defs.vh"
`timescale 1ns/100ps
module test_astd_exec;
    logic clock = 1'b0, nrst = 1'b0, ce = 1'b1, exec = 1'b0, wdf_set = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [9:0] opcode = 10'h000;
    logic [3:0] acc = 4'h0, breg = 4'h0, xin = 4'h0, yin = 4'h0, zin = 4'h0, reg_addr = 4'h0, reg_wdata = 4'h0;
    logic [3:0] reg_rdata, yreg, xreg, irq_ctl_one, irq_ctl_two, vector_en_one, serial_ctl, clock_ctl, converter_ctl, d;
    logic [2:0] data_ptr;
    logic [7:0] wide_reg, prescaler, prescaler_reload, serial_shift;
    logic [11:0] wakeup_ctl, pullup_ctl;
    logic [15:0] port_struct, timer_ctl;
    logic x_wr, y_wr, timer_bit, prescaler_load, osc_select, watchdog_flag_first, watchdog_run, skip_next, carry_keep;
    int errors = 0, n_checks = 0, seed;
    logic [9:0] ops [27] = '{`ASTD_OP_DPTR, `ASTD_OP_EREG, `ASTD_OP_PS0, `ASTD_OP_PS1, `ASTD_OP_PS2, `ASTD_OP_PS3,
        `ASTD_OP_IRQ1, `ASTD_OP_IRQ2, `ASTD_OP_VEN1, `ASTD_OP_SER, `ASTD_OP_WK0, `ASTD_OP_WK1, `ASTD_OP_WK2,
        `ASTD_OP_CLK, `ASTD_OP_TBIT, `ASTD_OP_PRE, `ASTD_OP_PU0, `ASTD_OP_PU1, `ASTD_OP_PU2, `ASTD_OP_ADC,
        `ASTD_OP_OSC, `ASTD_OP_SHF, `ASTD_OP_TM1, `ASTD_OP_TM2, `ASTD_OP_TM5, `ASTD_OP_TM6, `ASTD_OP_YREG};
    astd_exec uut (.clock, .nrst, .ce, .exec, .opcode, .acc, .breg, .xin, .yin, .zin, .wdf_set, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .data_ptr, .wide_reg, .yreg, .xreg, .x_wr, .y_wr, .port_struct,
        .irq_ctl_one, .irq_ctl_two, .vector_en_one, .serial_ctl, .wakeup_ctl, .clock_ctl, .timer_bit, .prescaler,
        .prescaler_reload, .prescaler_load, .pullup_ctl, .converter_ctl, .osc_select, .serial_shift, .timer_ctl,
        .watchdog_flag_first, .watchdog_run, .skip_next, .carry_keep);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] want(input logic [9:0] op);
        case (op)
            `ASTD_OP_DPTR: want = {5'h00, acc[2:0]};
            `ASTD_OP_EREG, `ASTD_OP_PRE, `ASTD_OP_SHF: want = {breg, acc};
            `ASTD_OP_TBIT, `ASTD_OP_OSC: want = {7'h00, acc[0]};
            default: want = {4'h0, acc};
        endcase
    endfunction
    function automatic logic [7:0] seen(input logic [9:0] op);
        case (op)
            `ASTD_OP_DPTR: seen = {5'h00, data_ptr};
            `ASTD_OP_EREG: seen = wide_reg;
            `ASTD_OP_PRE: seen = prescaler;
            `ASTD_OP_SHF: seen = serial_shift;
            `ASTD_OP_TBIT: seen = {7'h00, timer_bit};
            `ASTD_OP_OSC: seen = {7'h00, osc_select};
            `ASTD_OP_PS0, `ASTD_OP_PS1, `ASTD_OP_PS2, `ASTD_OP_PS3: seen = {4'h0, port_struct[op[1:0] * 4 +: 4]};
            `ASTD_OP_PU0, `ASTD_OP_PU1, `ASTD_OP_PU2: seen = {4'h0, pullup_ctl[(op[1:0] - 1) * 4 +: 4]};
            `ASTD_OP_IRQ1: seen = {4'h0, irq_ctl_one};
            `ASTD_OP_IRQ2: seen = {4'h0, irq_ctl_two};
            `ASTD_OP_VEN1: seen = {4'h0, vector_en_one};
            `ASTD_OP_SER: seen = {4'h0, serial_ctl};
            `ASTD_OP_CLK: seen = {4'h0, clock_ctl};
            `ASTD_OP_ADC: seen = {4'h0, converter_ctl};
            `ASTD_OP_WK0: seen = {4'h0, wakeup_ctl[3:0]};
            `ASTD_OP_WK1: seen = {4'h0, wakeup_ctl[7:4]};
            `ASTD_OP_WK2: seen = {4'h0, wakeup_ctl[11:8]};
            `ASTD_OP_TM1: seen = {4'h0, timer_ctl[3:0]};
            `ASTD_OP_TM2: seen = {4'h0, timer_ctl[7:4]};
            `ASTD_OP_TM5: seen = {4'h0, timer_ctl[11:8]};
            `ASTD_OP_TM6: seen = {4'h0, timer_ctl[15:12]};
            `ASTD_OP_YREG: seen = {4'h0, yreg};
            default: seen = 8'h00;
        endcase
    endfunction
    task automatic chk(input logic ok);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    // Issuing again before idle gives back-to-back execution
    task automatic issue(input logic [9:0] op);
        @(posedge clock);
        exec <= 1'b1;
        opcode <= op;
        acc <= 4'($urandom);
        breg <= 4'($urandom);
        xin <= 4'($urandom);
        yin <= 4'($urandom);
        zin <= 4'($urandom);
    endtask
    task automatic idle;
        @(posedge clock);
        exec <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [3:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // The flag passes a two-stage synchroniser, so allow a few edges
    task automatic flag_up;
        @(posedge clock);
        wdf_set <= 1'b1;
        repeat (5) @(posedge clock);
        wdf_set <= 1'b0;
        #1 chk(watchdog_flag_first === 1'b1);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        errors++;
        close_out();
    end
    initial begin
        seed = $urandom(32'hf0c8);
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        #1 chk(watchdog_run === 1'b1 && {port_struct, timer_ctl, wide_reg} === 40'h0);
        for (int i = 0; i < 27; i++) begin
            issue(ops[i]);
            idle();
            chk(seen(ops[i]) === want(ops[i]));
            chk(carry_keep === 1'b1 && skip_next === 1'b0);
            if (ops[i] == `ASTD_OP_PRE) chk(prescaler_reload === {breg, acc} && prescaler_load === 1'b1);
            if (ops[i] == `ASTD_OP_YREG) chk(y_wr === 1'b1);
        end
        for (int j = 0; j < 16; j += 15) begin
            issue({`ASTD_OP_STM_HI, 4'(j)});
            idle();
            chk(xreg === (xin ^ 4'(j)) && x_wr === 1'b1);
            rd(4'h4);
            chk(d === acc);
        end
        wr(4'h0, 4'h9);
        rd(4'h0);
        chk(d === 4'h9);
        rd(4'hf);
        chk(d === 4'h0);
        rd(4'h5);
        chk(d === zin);
        wr(4'h1, 4'h6);
        rd(4'h1);
        chk(d === 4'h6);
        rd(4'h2);
        chk(d === {1'b0, data_ptr});
        flag_up();
        issue(`ASTD_OP_WDS);
        idle();
        chk(watchdog_flag_first === 1'b0 && skip_next === 1'b1 && watchdog_run === 1'b1);
        issue(`ASTD_OP_WDS);
        idle();
        chk(skip_next === 1'b0);
        flag_up();
        issue(`ASTD_OP_WDD);
        issue(`ASTD_OP_WDS);
        idle();
        chk(watchdog_run === 1'b0 && skip_next === 1'b1);
        rd(4'h3);
        chk(d === 4'h0);
        issue(10'h3ff);
        idle();
        chk(carry_keep === 1'b0 && skip_next === 1'b0);
        // With the enable low nothing may move, not even a pulse
        d = yreg;
        @(posedge clock);
        ce <= 1'b0;
        issue(`ASTD_OP_YREG);
        idle();
        chk(y_wr === 1'b0 && carry_keep === 1'b0 && yreg === d);
        close_out();
    end
endmodule // test_astd_exec

// >>> hw/astd_exec.v
`include "astd_defs.vh"
`timescale 1ns/100ps
// How it works
// - Pointer load copies low three accumulator bits
// - B high nibble, A low into E
// - Opcodes load each wakeup control register
// - Store A at address {X,Y}, X xor immediate
// - Opcode 216 loads clock control register
// - Prescaler and reload take B:A together
// - Opcodes load each pull-up control register
// - Opcode 204 loads converter control register
// - Oscillator select takes accumulator bit 0
// - Serial shift register takes B:A
// - Opcodes load the four timer registers
// - Y load copies A, no skip
// - Watchdog service clears set flag unless the watchdog sets it that cycle, skips
// - Service after disable stops watchdog
module astd_exec (
    input wire clock,
    input wire nrst,
    input wire ce,
    input wire exec,
    input wire [9:0] opcode,
    input wire [3:0] acc,
    input wire [3:0] breg,
    input wire [3:0] xin,
    input wire [3:0] yin,
    input wire [3:0] zin,
    input wire wdf_set,
    input wire [3:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [3:0] reg_rdata,
    output reg [2:0] data_ptr,
    output reg [7:0] wide_reg,
    output reg [3:0] yreg,
    output reg [3:0] xreg,
    output reg x_wr,
    output reg y_wr,
    output reg [15:0] port_struct,
    output reg [3:0] irq_ctl_one,
    output reg [3:0] irq_ctl_two,
    output reg [3:0] vector_en_one,
    output reg [3:0] serial_ctl,
    output reg [11:0] wakeup_ctl,
    output reg [3:0] clock_ctl,
    output reg timer_bit,
    output reg [7:0] prescaler,
    output reg [7:0] prescaler_reload,
    output reg prescaler_load,
    output reg [11:0] pullup_ctl,
    output reg [3:0] converter_ctl,
    output reg osc_select,
    output reg [7:0] serial_shift,
    output reg [15:0] timer_ctl,
    output reg watchdog_flag_first,
    output reg watchdog_run,
    output reg skip_next,
    output reg carry_keep
);
////////////////////////////////////////////////////////////////////////////////
    wire [4:0] sel;
    wire [3:0] ram_q;
    wire ram_we;
    reg wdf_s0;
    reg wdf_s1;
    reg wdf_s2;
    reg last_disable;
    reg [3:0] next_rdata;
    wire go = ce && exec;

    function [7:0] pair;
        input [3:0] hi;
        input [3:0] lo;
        begin
            pair = {hi, lo};
        end
    endfunction

    astd_opdec u_dec (
        .opcode(opcode),
        .sel(sel)
    );

    assign ram_we = go && (sel == 5'h1f);

    // RAM address is {X,Y}; Z only shows on the register port
    astd_ram u_ram (
        .clock(clock),
        .ce(ce),
        .we(ram_we),
        .addr({xin, yin}),
        .wdata(acc),
        .rdata(ram_q)
    );
////////////////////////////////////////////////////////////////////////////////
    // Watchdog flag source lives elsewhere, so it is synchronised first
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wdf_s0 <= 1'b0;
            wdf_s1 <= 1'b0;
            wdf_s2 <= 1'b0;
        end else if (ce) begin
            wdf_s0 <= wdf_set;
            wdf_s1 <= wdf_s0;
            wdf_s2 <= wdf_s1;
        end
    end
    wire wdf_rise = wdf_s1 && !wdf_s2;
////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_ptr <= `ASTD_RST_DP;
            wide_reg <= `ASTD_RST_BYTE;
            yreg <= `ASTD_RST_NIB;
            xreg <= `ASTD_RST_NIB;
            x_wr <= 1'b0;
            y_wr <= 1'b0;
            port_struct <= 16'h0000;
            irq_ctl_one <= `ASTD_RST_NIB;
            irq_ctl_two <= `ASTD_RST_NIB;
            vector_en_one <= `ASTD_RST_NIB;
            serial_ctl <= `ASTD_RST_NIB;
            wakeup_ctl <= 12'h000;
            clock_ctl <= `ASTD_RST_NIB;
            timer_bit <= 1'b0;
            prescaler <= `ASTD_RST_BYTE;
            prescaler_reload <= `ASTD_RST_BYTE;
            prescaler_load <= 1'b0;
            pullup_ctl <= 12'h000;
            converter_ctl <= `ASTD_RST_NIB;
            osc_select <= 1'b0;
            serial_shift <= `ASTD_RST_BYTE;
            timer_ctl <= 16'h0000;
            watchdog_flag_first <= 1'b0;
            watchdog_run <= 1'b1;
            skip_next <= 1'b0;
            carry_keep <= 1'b0;
            last_disable <= 1'b0;
            reg_rdata <= `ASTD_RST_NIB;
        end else if (ce) begin
            x_wr <= 1'b0;
            y_wr <= 1'b0;
            prescaler_load <= 1'b0;
            skip_next <= 1'b0;
            carry_keep <= exec && (sel != 5'h00);
            reg_rdata <= next_rdata;
            // Flag set by the watchdog wins over a same-cycle service clear
            if (wdf_rise) begin
                watchdog_flag_first <= 1'b1;
            end
            if (exec) begin
                last_disable <= (opcode == `ASTD_OP_WDD);
                case (sel)
                    5'h01: data_ptr <= acc[2:0];
                    5'h02: wide_reg <= pair(breg, acc);
                    5'h03: port_struct[3:0] <= acc;
                    5'h04: port_struct[7:4] <= acc;
                    5'h05: port_struct[11:8] <= acc;
                    5'h06: port_struct[15:12] <= acc;
                    5'h07: irq_ctl_one <= acc;
                    5'h08: vector_en_one <= acc;
                    5'h1e: irq_ctl_two <= acc;
                    5'h0a: serial_ctl <= acc;
                    5'h0b: wakeup_ctl[3:0] <= acc;
                    5'h0c: wakeup_ctl[7:4] <= acc;
                    5'h0d: wakeup_ctl[11:8] <= acc;
                    5'h0e: clock_ctl <= acc;
                    5'h0f: timer_bit <= acc[0];
                    5'h10: begin
                        prescaler <= pair(breg, acc);
                        prescaler_reload <= pair(breg, acc);
                        prescaler_load <= 1'b1;
                    end
                    5'h11: pullup_ctl[3:0] <= acc;
                    5'h12: pullup_ctl[7:4] <= acc;
                    5'h13: pullup_ctl[11:8] <= acc;
                    5'h14: converter_ctl <= acc;
                    5'h15: osc_select <= acc[0];
                    5'h16: serial_shift <= pair(breg, acc);
                    5'h17: timer_ctl[3:0] <= acc;
                    5'h18: timer_ctl[7:4] <= acc;
                    5'h19: timer_ctl[11:8] <= acc;
                    5'h1a: timer_ctl[15:12] <= acc;
                    5'h1b: begin
                        yreg <= acc;
                        y_wr <= 1'b1;
                    end
                    5'h1c: begin
                        if (watchdog_flag_first && !wdf_rise) begin
                            watchdog_flag_first <= 1'b0;
                            skip_next <= 1'b1;
                        end else if (watchdog_flag_first) begin
                            skip_next <= 1'b1;
                        end
                        if (last_disable) begin
                            watchdog_run <= 1'b0;
                        end
                    end
                    5'h1f: begin
                        xreg <= xin ^ opcode[3:0];
                        x_wr <= 1'b1;
                    end
                    default: ;
                endcase
            end
            // Register port writes are refused while an instruction executes
            if (reg_wr && !exec) begin
                case (reg_addr)
                    4'h0: clock_ctl <= reg_wdata;
                    4'h1: serial_ctl <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
    // Read port shows internal state and the Z input; unmapped reads return zero
    always @* begin
        next_rdata = 4'h0;
        if (reg_rd) begin
            case (reg_addr)
                4'h0: next_rdata = clock_ctl;
                4'h1: next_rdata = serial_ctl;
                4'h2: next_rdata = {1'b0, data_ptr};
                4'h3: next_rdata = {2'b00, watchdog_run, watchdog_flag_first};
                4'h4: next_rdata = ram_q;
                4'h5: next_rdata = zin;
                default: next_rdata = 4'h0;
            endcase
        end
    end
endmodule // astd_exec

// >>> hw/astd_opdec.v
`timescale 1ns/100ps
`include "astd_defs.vh"
module astd_opdec (
    input wire [9:0] opcode,
    output reg [4:0] sel
);
    // Index of the target, 0 = none of this group
    always @* begin
        case (opcode)
            `ASTD_OP_DPTR: sel = 5'h01;
            `ASTD_OP_EREG: sel = 5'h02;
            `ASTD_OP_PS0: sel = 5'h03;
            `ASTD_OP_PS1: sel = 5'h04;
            `ASTD_OP_PS2: sel = 5'h05;
            `ASTD_OP_PS3: sel = 5'h06;
            `ASTD_OP_IRQ1: sel = 5'h07;
            `ASTD_OP_VEN1: sel = 5'h08;
            `ASTD_OP_VEN2: sel = 5'h09;
            `ASTD_OP_SER: sel = 5'h0a;
            `ASTD_OP_WK0: sel = 5'h0b;
            `ASTD_OP_WK1: sel = 5'h0c;
            `ASTD_OP_WK2: sel = 5'h0d;
            `ASTD_OP_CLK: sel = 5'h0e;
            `ASTD_OP_TBIT: sel = 5'h0f;
            `ASTD_OP_PRE: sel = 5'h10;
            `ASTD_OP_PU0: sel = 5'h11;
            `ASTD_OP_PU1: sel = 5'h12;
            `ASTD_OP_PU2: sel = 5'h13;
            `ASTD_OP_ADC: sel = 5'h14;
            `ASTD_OP_OSC: sel = 5'h15;
            `ASTD_OP_SHF: sel = 5'h16;
            `ASTD_OP_TM1: sel = 5'h17;
            `ASTD_OP_TM2: sel = 5'h18;
            `ASTD_OP_TM5: sel = 5'h19;
            `ASTD_OP_TM6: sel = 5'h1a;
            `ASTD_OP_YREG: sel = 5'h1b;
            `ASTD_OP_WDS: sel = 5'h1c;
            `ASTD_OP_WDD: sel = 5'h1d;
            `ASTD_OP_IRQ2: sel = 5'h1e;
            default: sel = (opcode[9:4] == `ASTD_OP_STM_HI) ? 5'h1f : 5'h00;
        endcase
    end
endmodule // astd_opdec

// >>> hw/astd_ram.v
`timescale 1ns/100ps
module astd_ram (
    input wire clock,
    input wire ce,
    input wire we,
    input wire [7:0] addr,
    input wire [3:0] wdata,
    output wire [3:0] rdata
);
    reg [3:0] mem [0:255];
    // No reset: RAM content is undefined at power up
    always @(posedge clock) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end
    assign rdata = mem[addr];
endmodule // astd_ram

// >>> pkg/astd_defs.vh
`ifndef ASTD_DEFS_VH
`define ASTD_DEFS_VH
// Opcodes, 10 bits
`define ASTD_OP_DPTR 10'h029
`define ASTD_OP_EREG 10'h01a
`define ASTD_OP_PS0 10'h228
`define ASTD_OP_PS1 10'h229
`define ASTD_OP_PS2 10'h22a
`define ASTD_OP_PS3 10'h22b
`define ASTD_OP_IRQ1 10'h217
`define ASTD_OP_VEN1 10'h03f
`define ASTD_OP_VEN2 10'h03e
`define ASTD_OP_SER 10'h202
`define ASTD_OP_WK0 10'h21b
`define ASTD_OP_WK1 10'h214
`define ASTD_OP_WK2 10'h215
`define ASTD_OP_IRQ2 10'h218
`define ASTD_OP_CLK 10'h216
`define ASTD_OP_TBIT 10'h2aa
`define ASTD_OP_PRE 10'h235
`define ASTD_OP_PU0 10'h22d
`define ASTD_OP_PU1 10'h22e
`define ASTD_OP_PU2 10'h22f
`define ASTD_OP_ADC 10'h204
`define ASTD_OP_OSC 10'h28b
`define ASTD_OP_SHF 10'h238
`define ASTD_OP_TM1 10'h20e
`define ASTD_OP_TM2 10'h20f
`define ASTD_OP_TM5 10'h212
`define ASTD_OP_TM6 10'h213
`define ASTD_OP_YREG 10'h00c
`define ASTD_OP_WDS 10'h2a0
`define ASTD_OP_WDD 10'h29c
// Store to RAM: upper 6 bits, low 4 bits immediate
`define ASTD_OP_STM_HI 6'h2b
// Reset values
`define ASTD_RST_NIB 4'h0
`define ASTD_RST_BYTE 8'h00
`define ASTD_RST_DP 3'h0
`endif
